// *** dv/positioning_target_mode_decode_tb.sv ***
// Testbench for the target mode decoder
`timescale 1ns/1ps
`default_nettype none
`include "ptm_regs.vh"
module positioning_target_mode_decode_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, move_done;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, q, hrdata, setpoint_pos, move_target, move_speed;
  logic hreadyout, hresp, move_start, move_abort, move_ccw, move_shortest, move_rel, move_busy;
  logic [7:0] dly = 8'h02;
  int miscompares = 0, samples_checked = 0, cyc = 0, i, n;
  // ==========================================
  // Rows: cfg, ctrl, mode, target, expected flags and target
  logic [2:0] cf [16] = '{2, 2, 2, 2, 2, 6, 3, 3, 3, 3, 0, 2, 0, 0, 0, 0};
  logic [15:0] cw [16] = '{0, 16'h1000, 16'h0800, 16'h1840, 16'h0040, 0, 0, 0, 0, 0, 16'h1800, 0, 0, 0, 0, 16'h0020};
  logic [15:0] mw [16] = '{0, 0, 0, 0, 0, 0, 1, 2, 4, 0, 0, 0, 0, 0, 0, 0};
  logic [31:0] tg [16] = '{32'h64, 32'hC8, 32'h32, 32'h1E, 32'hFFFFFFEC, 32'hA, 32'h5, 32'h7, 32'h8,
    32'h9, 32'h3, 32'h3, 32'h3E8, 32'h7D0, 32'hBB8, 32'h1F4};
  logic [4:0] ex [16] = '{5'h10, 5'h14, 5'h12, 5'h11, 5'h15, 5'h14, 5'h11, 5'h10, 5'h14, 5'h12, 5'h10, 5'h00,
    5'h10, 5'h00, 5'h00, 5'h18};
  logic [31:0] et [16] = '{32'h64, 32'hC8, 32'h32, 32'h50, 32'h3C, 32'hA, 32'hF, 32'h7, 32'h8, 32'h9, 32'h3,
    32'h3, 32'h3E8, 32'h3E8, 32'h3E8, 32'h1F4};
  // ==========================================
  // Clock, design and motion model
  always #2.5 hclk = ~hclk;
  ptm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .move_done(move_done), .setpoint_pos(setpoint_pos),
    .move_start(move_start), .move_abort(move_abort), .move_target(move_target), .move_ccw(move_ccw),
    .move_shortest(move_shortest), .move_rel(move_rel), .move_speed(move_speed), .move_busy(move_busy));
  ptm_motion_model u_mot (.hclk(hclk), .hresetn(hresetn), .move_start(move_start),
    .move_target(move_target), .dly(dly), .move_done(move_done), .setpoint_pos(setpoint_pos));
  // ==========================================
  // Closing report
  task results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // Single AHB transfer; waits on hready in both phases
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    // Select stays up; htrans IDLE marks the gap between transfers
  endtask
  // Bounded wait for the end of a move
  task idle;
    for (n = 0; n < 200 && move_busy !== 1'b0; n++) @(posedge hclk);
    chk("busy", 32'h0, {31'h0, move_busy});
  endtask
  // Load attributes, issue start, look at the launch cycle
  task row(input int r);
    ahb(1'b1, `PTM_OFS_CFG, {29'h0, cf[r]});
    ahb(1'b1, `PTM_OFS_CTRL, {16'h0, cw[r]});
    ahb(1'b1, `PTM_OFS_MODE, {16'h0, mw[r]});
    ahb(1'b1, `PTM_OFS_TARGET, tg[r]);
    ahb(1'b1, `PTM_OFS_CMD, 32'h1);
    #1;
    chk("flags", {27'h0, ex[r]}, {27'h0, move_start, move_abort, move_ccw, move_shortest, move_rel});
    chk("target", et[r], move_target);
    chk("speed", 32'h3E8, move_speed);
  endtask
  // Cycle ceiling
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `PTM_OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    ahb(1'b1, `PTM_OFS_SPEED, 32'hFFFFFC18);
    // Tg9 rows never ask for immediate start, as a telegram 9 master cannot
    for (i = 0; i < 16; i++) begin
      if (i == 12) dly <= 8'h28;
      if (i < 13) idle();
      row(i);
      if (i == 11) begin
        ahb(1'b0, `PTM_OFS_STATUS, 32'h0);
        chk("no move", 32'h20, q & 32'h20);
      end
      if (i == 14) begin
        // Live target changed while pending: launch must use the snapshot
        ahb(1'b1, `PTM_OFS_TARGET, 32'h0000_0123);
        for (n = 0; n < 100 && move_start !== 1'b1; n++) begin
          @(posedge hclk);
          #1;
        end
        chk("latest pending", 32'hBB8, move_target);
      end
    end
    idle();
    chk("after abort", 32'h1F4, move_target);
    ahb(1'b0, `PTM_OFS_CMD, 32'h0);
    chk("cmd reads 0", 32'h0, q);
    results();
  end
endmodule // positioning_target_mode_decode_tb
`default_nettype wire

// *** dv/ptm_motion_model.sv ***
// Motion logic model: finishes each move after a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module ptm_motion_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // From decoder
  input wire logic move_start,
  input wire logic [31:0] move_target,
  // Move length in cycles, 1 is prompt
  input wire logic [7:0] dly,
  // To decoder
  output logic move_done,
  output logic [31:0] setpoint_pos
);
  logic [7:0] cnt_r;
  // move timing
  // A start, aborting or not, restarts the count
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 8'h00;
      move_done <= 1'b0;
      setpoint_pos <= 32'h0;
    end else begin
      move_done <= 1'b0;
      if (move_start) begin
        cnt_r <= dly;
      end else if (cnt_r == 8'h01) begin
        cnt_r <= 8'h00;
        move_done <= 1'b1;
        setpoint_pos <= move_target; // Setpoint reaches target
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // ptm_motion_model
`default_nettype wire

// *** dv/ptm_top_checker.sv ***
// Port-level assertions for the target mode decoder
`timescale 1ns/1ps
`default_nettype none
module ptm_top_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Motion side
  input wire logic move_done,
  input wire logic move_start,
  input wire logic move_abort,
  input wire logic move_busy,
  input wire logic move_rel,
  input wire logic move_shortest,
  input wire logic [31:0] move_speed
);
  // ==========================================
  // Common clocking
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Bus never stalls and never errors
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_abort_when_busy: assert property (move_abort |-> $past(move_busy))
    else $error("abort without a running move");
  a_start_sets_busy: assert property (move_start |-> move_busy)
    else $error("start without busy");
  a_busy_from_start: assert property ($rose(move_busy) |-> move_start)
    else $error("busy rose without start");
  // Queued start only right after completion
  a_wait_for_done: assert property (move_start && !move_abort && $past(move_busy) |-> $past(move_done))
    else $error("start during run without done");
  a_rel_no_short: assert property (move_start && move_rel |-> !move_shortest)
    else $error("relative move flagged shortest");
  a_speed_mag: assert property (move_start |-> !move_speed[31])
    else $error("speed carries a sign");
  c_abort: cover property (move_abort);
endmodule // ptm_top_checker

bind ptm_top ptm_top_checker u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .move_done(move_done),
  .move_start(move_start),
  .move_abort(move_abort),
  .move_busy(move_busy),
  .move_rel(move_rel),
  .move_shortest(move_shortest),
  .move_speed(move_speed)
);
`default_nettype wire

// *** hw/ptm_ahb_if.v ***
// AHB-Lite slave front end: captures address phase, issues register strobes
`timescale 1ns/1ps
`default_nettype none
`include "ptm_regs.vh"

module ptm_ahb_if (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave side
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  // Register file side
  output wire wr_en,
  output wire [`PTM_AW-1:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [`PTM_AW-1:0] rd_addr,
  input wire [31:0] rd_data
);

  reg wr_pend_r;
  reg [`PTM_AW-1:0] wr_addr_r;
  wire take;

  // ==========================================================
  // Address phase
  // Only whole-word transfers are expected; hsize is not checked
  assign take = hsel & hready & htrans[1];
  assign rd_addr = haddr[`PTM_AW-1:0];

  // Write address held into the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= {`PTM_AW{1'b0}};
    end else begin
      wr_pend_r <= take & hwrite;
      if (take) begin
        wr_addr_r <= haddr[`PTM_AW-1:0];
      end
    end
  end

  // Read data registered so it stands for the whole data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      hrdata <= rd_data;
    end
  end

  // ==========================================================
  // Data phase: zero wait states, always OKAY
  assign wr_en = wr_pend_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = hwdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule // ptm_ahb_if
`default_nettype wire

// *** hw/ptm_attr_decode.v ***
// Decodes positioning attributes from control word or telegram 9 mode word
`timescale 1ns/1ps
`default_nettype none
`include "ptm_regs.vh"

module ptm_attr_decode (
  // Command words
  input wire [15:0] ctrl_word,
  input wire [15:0] mode_word,
  // Configuration
  input wire tg9_sel,
  input wire turntable,
  input wire value_neg,
  // Decoded attributes
  output reg rel,
  output reg immediate,
  output reg shortest,
  output reg ccw
);

  // ==========================================================
  // Attribute decode
  always @* begin
    // absolute or relative from control word; telegram 9 bit 0
    rel = tg9_sel ? mode_word[`PTM_MW_REL] : ctrl_word[`PTM_CW_REL];
    // telegram 9 cannot ask for immediate start
    immediate = tg9_sel ? 1'b0 : ctrl_word[`PTM_CW_IMM];
    shortest = 1'b0;
    ccw = 1'b0;
    if (turntable & rel) begin
      ccw = value_neg;
    end else if (turntable) begin
      if (tg9_sel) begin
        // bit1 cw, bit2 ccw, none shortest
        shortest = ~(mode_word[`PTM_MW_CW] | mode_word[`PTM_MW_CCW]);
        ccw = mode_word[`PTM_MW_CCW] & ~mode_word[`PTM_MW_CW];
      end else begin
        shortest = ctrl_word[`PTM_CW_SHORT];
        // bit 12 picks cw or ccw
        ccw = ~ctrl_word[`PTM_CW_SHORT] & ctrl_word[`PTM_CW_CCW];
      end
    end
  end

endmodule // ptm_attr_decode
`default_nettype wire

// *** hw/ptm_regs.vh ***
// Register offsets, attribute bit positions and reset values of the target mode decoder
`ifndef PTM_REGS_VH
`define PTM_REGS_VH

// ==========================================================
// Register byte offsets (word aligned)
`define PTM_AW 8
`define PTM_OFS_CTRL 8'h00
`define PTM_OFS_MODE 8'h04
`define PTM_OFS_TARGET 8'h08
`define PTM_OFS_CFG 8'h0C
`define PTM_OFS_SPEED 8'h10
`define PTM_OFS_CMD 8'h14
`define PTM_OFS_STATUS 8'h18
`define PTM_OFS_ACT_TGT 8'h1C
`define PTM_OFS_SETPOS 8'h20
`define PTM_OFS_ACT_SPD 8'h24

// ==========================================================
// Control word bits
`define PTM_CW_IMM 5
`define PTM_CW_REL 6
`define PTM_CW_SHORT 11
`define PTM_CW_CCW 12

// ==========================================================
// Telegram 9 mode word bits
`define PTM_MW_REL 0
`define PTM_MW_CW 1
`define PTM_MW_CCW 2

// ==========================================================
// Configuration and command bits
`define PTM_CFG_TG9 0
`define PTM_CFG_TURN 1
`define PTM_CFG_POLNEG 2
`define PTM_CMD_START 0

// ==========================================================
// Reset values
`define PTM_RST_WORD16 16'h0000
`define PTM_RST_WORD32 32'h0000_0000
`define PTM_RST_CFG 3'h0

`endif

// *** hw/ptm_top.v ***
// Positioning target mode decoder: register file, attribute capture and move sequencing
//
// Functional notes
// - Absolute: target equals commanded value
// - Relative: previous target plus commanded value
// - Telegram 9 bit 0 selects relative
// - Relative turntable: sign gives direction only
// - After-completion start waits for active move
// - Immediate start aborts move, starts new
// - Turntable movement choice only when absolute
// - Bit 11 clear: configured rotation direction
// - Bit 11 set: shortest path
// - Defined direction, bit 12 clear: clockwise
// - Defined direction, bit 12 set: counter-clockwise
// - Telegram 9 bits 1/2: cw, ccw, shortest
// - Negative polarity inverts direction globally
// - Speed sign never sets direction
// - Pending after-completion commands not queued, latest wins
// - Absolute turntable target at setpoint: no move
`timescale 1ns/1ps
`default_nettype none
`include "ptm_regs.vh"

module ptm_top (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  // Motion controller side (same clock)
  input wire move_done,
  input wire [31:0] setpoint_pos,
  output wire move_start,
  output wire move_abort,
  output reg [31:0] move_target,
  output reg move_ccw,
  output reg move_shortest,
  output reg move_rel,
  output reg [31:0] move_speed,
  output wire move_busy
);

  // ==========================================================
  // Sequencer states
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  // Bus strobes
  wire wr_en;
  wire [`PTM_AW-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [`PTM_AW-1:0] rd_addr;
  reg [31:0] rd_data;

  // Software registers
  reg [15:0] ctrl_r;
  reg [15:0] mode_r;
  reg [31:0] value_r;
  reg [2:0] cfg_r;
  reg [31:0] speed_r;

  // Sequencer state
  reg state_r;
  reg state_nxt;
  reg pend_r;
  reg pend_nxt;
  reg [31:0] pend_val_r;
  reg pend_rel_r;
  reg pend_short_r;
  reg pend_ccw_r;
  reg start_r;
  reg abort_r;
  reg nomove_r;

  // Decoder outputs
  wire dec_rel;
  wire dec_imm;
  wire dec_short;
  wire dec_ccw;

  // Launch selection
  wire cmd;
  wire launch_cmd;
  wire launch_pend;
  wire launch;
  reg [31:0] l_val;
  reg l_rel;
  reg l_short;
  reg l_ccw;
  wire [31:0] l_target;
  wire l_nomove;
  wire [31:0] speed_mag;

  // ==========================================================
  // Bus front end
  ptm_ahb_if u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ==========================================================
  // Attribute decode of the live command words
  ptm_attr_decode u_dec (
    .ctrl_word(ctrl_r),
    .mode_word(mode_r),
    .tg9_sel(cfg_r[`PTM_CFG_TG9]),
    .turntable(cfg_r[`PTM_CFG_TURN]),
    .value_neg(value_r[31]),
    .rel(dec_rel),
    .immediate(dec_imm),
    .shortest(dec_short),
    .ccw(dec_ccw)
  );

  // ==========================================================
  // Register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `PTM_RST_WORD16;
      mode_r <= `PTM_RST_WORD16;
      value_r <= `PTM_RST_WORD32;
      cfg_r <= `PTM_RST_CFG;
      speed_r <= `PTM_RST_WORD32;
    end else if (wr_en) begin
      case (wr_addr)
        `PTM_OFS_CTRL: ctrl_r <= wr_data[15:0];
        `PTM_OFS_MODE: mode_r <= wr_data[15:0];
        `PTM_OFS_TARGET: value_r <= wr_data;
        `PTM_OFS_CFG: cfg_r <= wr_data[2:0];
        `PTM_OFS_SPEED: speed_r <= wr_data;
        default: ;
      endcase
    end
  end

  // Start command: a write of 1 to the start bit of the command register
  assign cmd = wr_en & (wr_addr == `PTM_OFS_CMD) & wr_data[`PTM_CMD_START];

  // ==========================================================
  // Launch decision
  // immediate start goes out at once
  // after-completion waits while a move runs
  assign launch_cmd = cmd & (dec_imm | (state_r == ST_IDLE) | move_done);
  // Latest command wins over a stored one in the done cycle
  assign launch_pend = pend_r & move_done & ~cmd;
  assign launch = launch_cmd | launch_pend;

  // Source of the attributes for the launched move
  always @* begin
    if (launch_cmd) begin
      l_val = value_r;
      l_rel = dec_rel;
      l_short = dec_short;
      l_ccw = dec_ccw;
    end else begin
      l_val = pend_val_r;
      l_rel = pend_rel_r;
      l_short = pend_short_r;
      l_ccw = pend_ccw_r;
    end
  end

  // absolute load; add to previous target
  assign l_target = l_rel ? move_target + l_val : l_val;
  assign l_nomove = cfg_r[`PTM_CFG_TURN] & ~l_rel & (l_val == setpoint_pos);
  // only the speed magnitude is used
  assign speed_mag = speed_r[31] ? (~speed_r + 32'h0000_0001) : speed_r;

  // ==========================================================
  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    case (state_r)
      ST_IDLE: begin
        pend_nxt = 1'b0;
        if (launch & ~l_nomove) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (launch) begin
          pend_nxt = 1'b0;
          if (l_nomove) begin
            state_nxt = ST_IDLE;
          end
        end else if (move_done) begin
          state_nxt = ST_IDLE;
        end
        // a waiting command overwrites the stored one
        if (cmd & ~launch_cmd) begin
          pend_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        pend_nxt = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Sequencer registers and pending snapshot
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      pend_r <= 1'b0;
      pend_val_r <= `PTM_RST_WORD32;
      pend_rel_r <= 1'b0;
      pend_short_r <= 1'b0;
      pend_ccw_r <= 1'b0;
      start_r <= 1'b0;
      abort_r <= 1'b0;
      nomove_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      start_r <= launch & ~l_nomove;
      // running move aborted by an immediate command
      abort_r <= launch_cmd & dec_imm & (state_r == ST_RUN) & ~move_done;
      if (launch) begin
        nomove_r <= l_nomove;
      end
      // attributes frozen when the command is taken
      if (cmd & ~launch_cmd) begin
        pend_val_r <= value_r;
        pend_rel_r <= dec_rel;
        pend_short_r <= dec_short;
        pend_ccw_r <= dec_ccw;
      end
    end
  end

  // ==========================================================
  // Move outputs, loaded only at launch
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      move_target <= `PTM_RST_WORD32;
      move_ccw <= 1'b0;
      move_shortest <= 1'b0;
      move_rel <= 1'b0;
      move_speed <= `PTM_RST_WORD32;
    end else if (launch) begin
      // target update even when no motion follows
      move_target <= l_target;
      move_ccw <= l_ccw ^ cfg_r[`PTM_CFG_POLNEG];
      move_shortest <= l_short;
      move_rel <= l_rel;
      move_speed <= speed_mag;
    end
  end

  assign move_start = start_r;
  assign move_abort = abort_r;
  assign move_busy = (state_r == ST_RUN);

  // ==========================================================
  // Read mux; unmapped offsets read as zero
  always @* begin
    case (rd_addr)
      `PTM_OFS_CTRL: rd_data = {16'h0000, ctrl_r};
      `PTM_OFS_MODE: rd_data = {16'h0000, mode_r};
      `PTM_OFS_TARGET: rd_data = value_r;
      `PTM_OFS_CFG: rd_data = {29'h0000_0000, cfg_r};
      `PTM_OFS_SPEED: rd_data = speed_r;
      `PTM_OFS_STATUS: rd_data = {26'h000_0000, nomove_r, move_rel, move_shortest, move_ccw, pend_r, move_busy};
      `PTM_OFS_ACT_TGT: rd_data = move_target;
      `PTM_OFS_SETPOS: rd_data = setpoint_pos;
      `PTM_OFS_ACT_SPD: rd_data = move_speed;
      default: rd_data = 32'h0000_0000;
    endcase
  end

endmodule // ptm_top
`default_nettype wire
